// ==== logic/bssp_pkg.sv ====
package bssp_pkg;

  // Register map on the plain byte bus
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] CTRL_ONE_ADDR = 16'h1f96;
  localparam logic [15:0] WCW_STAT_ADDR = 16'h1f97;
  localparam logic [15:0] BUF_BASE_ADDR = 16'h1f98;

  // Field positions of serial_ctrl_one
  localparam int unsigned CTRL_START_BIT = 7;
  localparam int unsigned CTRL_ABORT_BIT = 6;
  localparam int unsigned CTRL_MODE_LSB = 3;
  localparam int unsigned CTRL_SCK_LSB = 0;

  // Field positions of word_count_wait_ctrl
  localparam int unsigned WCW_WAIT_LSB = 3;
  localparam int unsigned WCW_COUNT_LSB = 0;

  // Field positions of transfer_status
  localparam int unsigned STAT_ACTIVE_BIT = 7;
  localparam int unsigned STAT_SHIFT_BIT = 6;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [4:0] WCW_RST = 5'h00;
  localparam logic [7:0] BUF_RST = 8'h00;

  // Transfer modes
  localparam logic [2:0] MODE_TX8 = 3'h0;
  localparam logic [2:0] MODE_TX4 = 3'h2;
  localparam logic [2:0] MODE_TXRX8 = 3'h4;
  localparam logic [2:0] MODE_RX8 = 3'h5;
  localparam logic [2:0] MODE_RX4 = 3'h6;

  // Clock select code for the external clock on the pin
  localparam logic [2:0] SCK_EXT = 3'h7;

  // Half periods of the internal serial clock in system clocks, minus one
  localparam logic [11:0] HALF_SEL0 = 12'h0fff;
  localparam logic [11:0] HALF_SEL1 = 12'h007f;
  localparam logic [11:0] HALF_SEL2 = 12'h003f;
  localparam logic [11:0] HALF_SEL3 = 12'h001f;
  localparam logic [11:0] HALF_SEL4 = 12'h000f;
  localparam logic [11:0] HALF_SEL5 = 12'h0007;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b10,
    ST_HOLD = 2'b11
  } bssp_state_t;

  // Serial pin group
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic sdo;
  } bssp_pins_t;

  // Engine state
  typedef struct packed {
    bssp_state_t st;
    logic [2:0] idx;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [11:0] div;
    logic [7:0] gap;
    logic sck;
    logic sdo;
    logic pend;
    logic sy1;
    logic sy2;
    logic sy3;
    logic ext_lvl;
  } bssp_eng_t;

endpackage : bssp_pkg

// ==== logic/bssp_top.sv ====
// What this block does
// - Wait field stretches frame to 1,2,4,8 times in transmit-and-receive mode with internal clock
// - Word count picks 1 to 8 buffer words
// - Four-bit mode zeroes received upper nibble
// - Words go lowest buffer address first
// - Word count survives the end of transfer
// - Status bit7 transfer active, bit6 shifting
// - Active flag clears on stop or abort
// - Six internal rates or external pin clock
// - Internal clock pin goes high at start
// - Internal clock pauses until buffer serviced
// - Transmit bits change on falling pin edge
// - Receive bits sampled on rising pin edge
// - Every word goes least significant bit first
// - Done pulse after the selected word count
// - Mode field selects transmit, receive or both
// - Abort ends transfer at once, mid-word
//
// Strobed register access was chosen for this implementation.
module bssp_top (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [bssp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial pins
  input wire logic sck_in,
  input wire logic sdi,
  output bssp_pkg::bssp_pins_t pins,
  // Event
  output logic transfer_done_irq
);
  import bssp_pkg::*;

  // Decode helpers for the register paths and the serial engine
  function automatic logic buf_hit(input logic [ADDR_W-1:0] a);
    buf_hit = (a[ADDR_W-1:3] == BUF_BASE_ADDR[ADDR_W-1:3]);
  endfunction : buf_hit

  function automatic logic mode_tx(input logic [2:0] m);
    mode_tx = (m == MODE_TX8) || (m == MODE_TX4) || (m == MODE_TXRX8);
  endfunction : mode_tx

  function automatic logic mode_rx(input logic [2:0] m);
    mode_rx = (m == MODE_RX8) || (m == MODE_RX4) || (m == MODE_TXRX8);
  endfunction : mode_rx

  function automatic logic mode_w4(input logic [2:0] m);
    mode_w4 = (m == MODE_TX4) || (m == MODE_RX4);
  endfunction : mode_w4

  function automatic logic [11:0] half_period(input logic [2:0] s);
    case (s)
      3'h1: half_period = HALF_SEL1;
      3'h2: half_period = HALF_SEL2;
      3'h3: half_period = HALF_SEL3;
      3'h4: half_period = HALF_SEL4;
      3'h5: half_period = HALF_SEL5;
      default: half_period = HALF_SEL0;
    endcase
  endfunction : half_period

  // Software-visible registers
  logic start_q, start_d;
  logic [2:0] mode_q, mode_d;
  logic [2:0] sel_q, sel_d;
  logic [1:0] wait_q, wait_d;
  logic [2:0] count_q, count_d;
  logic [7:0] buf_q [8];
  logic [7:0] buf_d [8];
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  bssp_eng_t e_q, e_d;

  // Decoded controls
  logic ext_clk, w4, abort_req, fall_ev, rise_ev, last_bit, last_word;
  logic [7:0] sh_in;
  logic [7:0] gap_len;

  assign ext_clk = (sel_q == SCK_EXT);
  assign w4 = mode_w4(mode_q);
  assign abort_req = reg_wr && (reg_addr == CTRL_ONE_ADDR)
                     && reg_wdata[CTRL_ABORT_BIT];
  assign last_bit = w4 ? (e_q.bit_cnt == 3'h3) : (e_q.bit_cnt == 3'h7);
  assign last_word = (e_q.idx == count_q);
  // Idle gap between words: (multiplier - 1) words of half periods
  assign gap_len = (wait_q == 2'h1) ? 8'h0f
                 : (wait_q == 2'h2) ? 8'h2f
                 : 8'h6f;

  // Outputs all come from flip-flops except the pin enable decode
  assign reg_rdata = rdata_q;
  assign transfer_done_irq = irq_q;
  assign pins.sck = e_q.sck;
  assign pins.sdo = e_q.sdo;
  assign pins.sck_oe = !ext_clk;

  // Next-state logic for registers, buffer and serial engine
  always_comb begin
    start_d = start_q;
    mode_d = mode_q;
    sel_d = sel_q;
    wait_d = wait_q;
    count_d = count_q;
    buf_d = buf_q;
    rdata_d = 8'h00;
    irq_d = 1'b0;
    e_d = e_q;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    sh_in = 8'h00;

    // Pin clock filter; the first stage only feeds the second
    e_d.sy1 = sck_in;
    e_d.sy2 = e_q.sy1;
    e_d.sy3 = e_q.sy2;
    if (e_q.sy2 == e_q.sy3) begin
      e_d.ext_lvl = e_q.sy3;
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr == CTRL_ONE_ADDR) begin
        start_d = reg_wdata[CTRL_START_BIT];
        mode_d = reg_wdata[CTRL_MODE_LSB +: 3];
        sel_d = reg_wdata[CTRL_SCK_LSB +: 3];
      end else if (reg_addr == WCW_STAT_ADDR) begin
        wait_d = reg_wdata[WCW_WAIT_LSB +: 2];
        count_d = reg_wdata[WCW_COUNT_LSB +: 3];
      end else if (buf_hit(reg_addr)) begin
        buf_d[reg_addr[2:0]] = reg_wdata;
        if (mode_tx(mode_q) && !mode_rx(mode_q)) begin
          e_d.pend = 1'b0;
        end
      end
    end

    // Register reads; data stand one cycle later
    if (reg_rd) begin
      if (reg_addr == WCW_STAT_ADDR) begin
        rdata_d[STAT_ACTIVE_BIT] = (e_q.st != ST_IDLE);
        rdata_d[STAT_SHIFT_BIT] = (e_q.st == ST_SHIFT);
      end else if (buf_hit(reg_addr)) begin
        rdata_d = buf_q[reg_addr[2:0]];
        if (mode_rx(mode_q)) begin
          e_d.pend = 1'b0;
        end
      end
    end

    // Internal serial clock divider runs while shifting or gapping
    if (!ext_clk && (e_q.st == ST_SHIFT || e_q.st == ST_GAP)) begin
      if (e_q.div == 12'h000) begin
        e_d.div = half_period(sel_q);
        if (e_q.st == ST_SHIFT) begin
          e_d.sck = !e_q.sck;
          fall_ev = e_q.sck;
          rise_ev = !e_q.sck;
        end else if (e_q.gap == 8'h00) begin
          e_d.st = ST_SHIFT;
          e_d.shreg = buf_q[e_q.idx];
        end else begin
          e_d.gap = e_q.gap - 8'h01;
        end
      end else begin
        e_d.div = e_q.div - 12'h001;
      end
    end else if (ext_clk && e_q.st == ST_SHIFT) begin
      fall_ev = e_q.ext_lvl && !e_d.ext_lvl;
      rise_ev = !e_q.ext_lvl && e_d.ext_lvl;
    end

    case (e_q.st)
      ST_IDLE: begin
        e_d.sck = 1'b1;
        e_d.sdo = 1'b1;
        if (start_q && !abort_req) begin
          e_d.st = ST_SHIFT;
          e_d.idx = 3'h0;
          e_d.bit_cnt = 3'h0;
          e_d.shreg = buf_q[0];
          e_d.div = half_period(sel_q);
          e_d.pend = 1'b0;
          e_d.sck = 1'b1;
        end
      end
      ST_SHIFT: begin
        if (fall_ev && mode_tx(mode_q)) begin
          e_d.sdo = e_q.shreg[0];
        end
        if (rise_ev) begin
          // Sampled bit enters at the word's top so LSB lands at bit 0
          if (w4) begin
            sh_in = {4'h0, sdi, e_q.shreg[3:1]};
          end else begin
            sh_in = {sdi, e_q.shreg[7:1]};
          end
          e_d.shreg = sh_in;
          e_d.bit_cnt = e_q.bit_cnt + 3'h1;
          if (last_bit) begin
            e_d.bit_cnt = 3'h0;
            if (ext_clk && e_q.pend) begin
              // Buffer not serviced in time: drop the word and stop
              e_d.st = ST_IDLE;
              e_d.pend = 1'b0;
            end else begin
              if (mode_rx(mode_q)) begin
                buf_d[e_q.idx] = sh_in;
              end
              if (last_word) begin
                irq_d = 1'b1;
                e_d.pend = 1'b1;
                e_d.idx = 3'h0;
                if (!start_q) begin
                  e_d.st = ST_IDLE;
                end else if (!ext_clk) begin
                  e_d.st = ST_HOLD;
                end else begin
                  e_d.shreg = buf_q[0];
                end
              end else begin
                e_d.idx = e_q.idx + 3'h1;
                if (!start_q) begin
                  e_d.st = ST_IDLE;
                end else if (!ext_clk && mode_q == MODE_TXRX8
                             && wait_q != 2'h0) begin
                  e_d.st = ST_GAP;
                  e_d.gap = gap_len;
                end else begin
                  e_d.shreg = buf_q[e_q.idx + 3'h1];
                end
              end
            end
          end
        end
      end
      ST_GAP: begin
        e_d.sck = 1'b1;
        if (!start_q) begin
          e_d.st = ST_IDLE;
        end
      end
      ST_HOLD: begin
        // Clock parked high until software writes the buffer (transmit-only modes) or reads it (receive modes)
        e_d.sck = 1'b1;
        if (!start_q) begin
          e_d.st = ST_IDLE;
          e_d.pend = 1'b0;
        end else if (!e_d.pend) begin
          e_d.st = ST_SHIFT;
          e_d.idx = 3'h0;
          e_d.shreg = buf_d[0];
          e_d.div = half_period(sel_q);
        end
      end
      default: begin
        e_d.st = ST_IDLE;
      end
    endcase

    // Abort overrides the engine state and drops the word, unless its last bit lands in the same cycle
    if (abort_req) begin
      e_d.st = ST_IDLE;
      e_d.bit_cnt = 3'h0;
      e_d.idx = 3'h0;
      e_d.pend = 1'b0;
      e_d.sck = 1'b1;
      e_d.sdo = 1'b1;
    end
  end

  // Registers; count and wait keep their value across transfers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      start_q <= CTRL_ONE_RST[CTRL_START_BIT];
      mode_q <= CTRL_ONE_RST[CTRL_MODE_LSB +: 3];
      sel_q <= CTRL_ONE_RST[CTRL_SCK_LSB +: 3];
      wait_q <= WCW_RST[WCW_WAIT_LSB +: 2];
      count_q <= WCW_RST[WCW_COUNT_LSB +: 3];
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      e_q <= '{st: ST_IDLE, sck: 1'b1, sdo: 1'b1, sy1: 1'b1,
               sy2: 1'b1, sy3: 1'b1, ext_lvl: 1'b1, default: '0};
      for (int i = 0; i < 8; i++) begin
        buf_q[i] <= BUF_RST;
      end
    end else if (clk_en) begin
      start_q <= start_d;
      mode_q <= mode_d;
      sel_q <= sel_d;
      wait_q <= wait_d;
      count_q <= count_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      e_q <= e_d;
      buf_q <= buf_d;
    end
  end

endmodule : bssp_top

// ==== testbench/bssp_top_checker.sv ====
module bssp_top_checker
  import bssp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Serial side
  input wire logic sck_in,
  input wire logic sdi,
  input wire bssp_pkg::bssp_pins_t pins,
  input wire logic transfer_done_irq
);
  // Frozen cycles are skipped, so pulses count in enabled cycles only
  default clocking cb @(posedge clock iff clk_en);
  endclocking
  default disable iff (sys_rst);

  // Read data only in the slot after a read
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside
    {[WCW_STAT_ADDR:16'h1f9f]}) |=> reg_rdata == 8'h00)
    else $error("control or unmapped read not zero");
  chk_status_unused: assert property (reg_rd && reg_addr == WCW_STAT_ADDR
    |=> reg_rdata[5:0] == 6'h00)
    else $error("status low bits not zero");
  // Done is a single pulse, seen with the pin high after the last rise
  chk_done_pulse: assert property (transfer_done_irq |=> !transfer_done_irq)
    else $error("done longer than one cycle");
  chk_done_high: assert property (transfer_done_irq |-> pins.sck)
    else $error("done while clock pin low");
  // Data out moves only on a falling pin edge, writes may reset it
  chk_sdo_fall: assert property ($changed(pins.sdo) && !$past(reg_wr)
    |-> $fell(pins.sck))
    else $error("data out moved off the falling edge");
  chk_oe_internal: assert property (reg_wr && reg_addr == CTRL_ONE_ADDR &&
    reg_wdata[2:0] != SCK_EXT |=> pins.sck_oe)
    else $error("clock pin not driven for internal clock");
  chk_start_high: assert property (reg_wr && reg_addr == CTRL_ONE_ADDR &&
    reg_wdata[7:6] == 2'b10 |=> pins.sck [*4])
    else $error("clock pin not high at start");

  cover property (transfer_done_irq);
  cover property ($fell(pins.sck));
  cover property (reg_rd && reg_addr == WCW_STAT_ADDR);
endmodule : bssp_top_checker

bind bssp_top bssp_top_checker i_bssp_top_checker (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sck_in(sck_in), .sdi(sdi), .pins(pins),
  .transfer_done_irq(transfer_done_irq));

// ==== testbench/bssp_peer.sv ====
module bssp_peer (
  // Bench control
  input wire logic rst,
  input wire logic [7:0] tx_byte,
  // Serial pins
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] n;

  // Next bit on the falling edge; index wraps so eight-bit words repeat the byte
  always @(negedge sck or posedge rst) begin
    if (rst) begin
      n <= 3'h0;
      sdi <= 1'b1;
    end else begin
      sdi <= tx_byte[n];
      n <= n + 3'h1;
    end
  end

  // Device data captured on the rising edge, first bit ends lowest
  always @(posedge sck) begin
    rx_byte <= {sdo, rx_byte[7:1]};
  end
endmodule : bssp_peer

// ==== testbench/bssp_top_bench.sv ====
module bssp_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bssp_pkg::*;
  logic clock, sys_rst, reg_wr, reg_rd, irq, sdi, sck_in, peer_rst;
  logic clk_en, ext_sck;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, peer_rx;
  bssp_pins_t pins;
  int fail_count = 0;
  int n_tests = 0;
  int irq_cycles;

  bssp_top i_bssp_top (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_in(sck_in), .sdi(sdi),
    .pins(pins), .transfer_done_irq(irq));
  bssp_peer i_bssp_peer (.rst(peer_rst), .tx_byte(8'h96), .sck(sck_in),
    .sdo(pins.sdo), .sdi(sdi), .rx_byte(peer_rx));

  // Bench drives the clock line when the device lets go; it idles high
  assign sck_in = pins.sck_oe ? pins.sck : ext_sck;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp

  // Cycles from the end of the start write (one idle cycle after its strobe) to the done pulse
  task automatic cmp_cycles(input int e);
    n_tests++;
    if (irq_cycles != e) begin
      fail_count++;
      $display("unexpected at %0t: %0d cycles, want %0d", $time,
               irq_cycles, e);
    end
  endtask : cmp_cycles

  // One idle cycle after each strobe so no strobe is set twice at an edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, e);
    @(posedge clock);
  endtask : chk_rd

  task automatic wait_irq();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      i++;
    end while (irq !== 1'b1 && i < 3000);
    irq_cycles = i;
    cmp({7'h00, irq}, 8'h01);
    @(posedge clock);
  endtask : wait_irq

  // Stop and abort, set mode, start, then check the automatic wait
  task automatic run(input logic [2:0] mode);
    wr(CTRL_ONE_ADDR, {2'b01, mode, 3'h5});
    peer_rst <= 1'b1;
    @(posedge clock);
    peer_rst <= 1'b0;
    wr(CTRL_ONE_ADDR, {2'b10, mode, 3'h5});
    wait_irq();
    repeat (40) @(posedge clock);
    cmp({7'h00, pins.sck}, 8'h01);
    chk_rd(WCW_STAT_ADDR, 8'h80);
    wr(CTRL_ONE_ADDR, {2'b01, mode, 3'h5});
    chk_rd(WCW_STAT_ADDR, 8'h00);
  endtask : run

  // Cut a hang short well past the expected run of under two thousand cycles
  initial begin
    repeat (8000) @(posedge clock);
    fail_count++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    peer_rst = 1'b1;
    clk_en = 1'b1;
    ext_sck = 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    peer_rst <= 1'b0;
    @(posedge clock);
    chk_rd(WCW_STAT_ADDR, 8'h00);
    chk_rd(CTRL_ONE_ADDR, 8'h00);
    chk_rd(16'h1f90, 8'h00);
    wr(BUF_BASE_ADDR + 16'h0007, 8'h5a);
    chk_rd(BUF_BASE_ADDR + 16'h0007, 8'h5a);
    // Frozen clock enable: a write in that time must not land
    clk_en <= 1'b0;
    wr(BUF_BASE_ADDR + 16'h0007, 8'h11);
    clk_en <= 1'b1;
    chk_rd(BUF_BASE_ADDR + 16'h0007, 8'h5a);
    wr(WCW_STAT_ADDR, 8'h01);
    chk_rd(WCW_STAT_ADDR, 8'h00);
    wr(BUF_BASE_ADDR, 8'ha5);
    wr(BUF_BASE_ADDR + 16'h0001, 8'h3c);
    run(MODE_TX8);
    cmp_cycles(256);
    cmp(peer_rx, 8'h3c);
    // Abort in mid-word ends the transfer at once
    wr(CTRL_ONE_ADDR, {2'b10, MODE_TX8, 3'h5});
    repeat (30) @(posedge clock);
    wr(CTRL_ONE_ADDR, {2'b01, MODE_TX8, 3'h5});
    chk_rd(WCW_STAT_ADDR, 8'h00);
    // Count of two words kept from the first run
    run(MODE_RX4);
    chk_rd(BUF_BASE_ADDR, 8'h06);
    chk_rd(BUF_BASE_ADDR + 16'h0001, 8'h09);
    wr(WCW_STAT_ADDR, 8'h00);
    run(MODE_RX8);
    chk_rd(BUF_BASE_ADDR, 8'h96);
    chk_rd(BUF_BASE_ADDR + 16'h0001, 8'h09);
    // Both directions, one word time of wait before the second word
    wr(WCW_STAT_ADDR, 8'h09);
    run(MODE_TXRX8);
    cmp_cycles(384);
    cmp(peer_rx, 8'h09);
    chk_rd(BUF_BASE_ADDR + 16'h0001, 8'h96);
    // External clock from the bench, phases well over sixteen cycles
    wr(WCW_STAT_ADDR, 8'h00);
    wr(CTRL_ONE_ADDR, {2'b01, MODE_RX4, SCK_EXT});
    cmp({7'h00, pins.sck_oe}, 8'h00);
    peer_rst <= 1'b1;
    @(posedge clock);
    peer_rst <= 1'b0;
    wr(CTRL_ONE_ADDR, {2'b10, MODE_RX4, SCK_EXT});
    fork
      repeat (4) begin
        ext_sck <= 1'b0;
        repeat (20) @(posedge clock);
        ext_sck <= 1'b1;
        repeat (20) @(posedge clock);
      end
      wait_irq();
    join
    chk_rd(WCW_STAT_ADDR, 8'hc0);
    wr(CTRL_ONE_ADDR, {2'b01, MODE_RX4, SCK_EXT});
    chk_rd(BUF_BASE_ADDR, 8'h06);
    close_out();
  end
endmodule : bssp_top_bench
